// ===== verilog/cpc_pkg.sv
package cpc_pkg;
    // Register pointers
    localparam logic [7:0] PTR_SETUP = 8'h00;
    localparam logic [7:0] PTR_SHUNT = 8'h01;
    localparam logic [7:0] PTR_BUS   = 8'h02;
    localparam logic [7:0] PTR_POWER = 8'h03;
    localparam logic [7:0] PTR_CURR  = 8'h04;
    localparam logic [7:0] PTR_SCALE = 8'h05;

    // Reset values
    localparam logic [15:0] SETUP_RESET = 16'h399f;
    localparam logic [15:0] SCALE_RESET = 16'h0000;
    localparam logic [15:0] ZERO16      = 16'h0000;

    // Field layout
    localparam int SETUP_RST_BIT = 15;
    localparam int BUS_SHIFT     = 3;
    localparam int BUS_BITS      = 13;

    // Arithmetic constants
    localparam logic [15:0] CURR_DIVISOR = 16'd4095;
    localparam logic [15:0] PWR_DIVISOR  = 16'd5000;
    localparam logic [15:0] CURR_MAG_MAX = 16'h7fff;
    localparam logic [15:0] PWR_MAX      = 16'hffff;

    // Write-to-apply bound
    localparam int APPLY_TIME_NS = 4000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int APPLY_CYCLES  = APPLY_TIME_NS / CLK_PERIOD_NS;

    // Result sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CURR_GO,
        ST_CURR_WAIT,
        ST_PWR_GO,
        ST_PWR_WAIT
    } cpc_state_t;
endpackage

// ===== verilog/cpc_divider.sv
`timescale 1ns/10ps
// Restoring unsigned divider, one quotient bit per clock, truncates toward zero
module cpc_divider #(
    parameter int DW = 32,
    parameter int VW = 16
) (
    input  wire logic          core_clk,  // System clock
    input  wire logic          rst,       // Synchronous reset
    input  wire logic          start,     // Begin a division
    input  wire logic [DW-1:0] dividend,  // Unsigned dividend
    input  wire logic [VW-1:0] divisor,   // Unsigned divisor, nonzero
    output logic               busy,      // Division in progress
    output logic               done,      // One-cycle completion pulse
    output logic      [DW-1:0] quotient   // Result, held until next start
);
    localparam int CW = $clog2(DW + 1);

    logic [VW:0]   rem;
    logic [DW-1:0] quo;
    logic [CW-1:0] cnt;
    logic [VW:0]   next_rem;
    logic [DW-1:0] next_quo;
    logic [CW-1:0] next_cnt;
    logic          next_busy;
    logic          next_done;
    logic [VW:0]   shifted;

    // Shift one dividend bit into the remainder and try the subtraction
    always_comb
    begin
        next_rem  = rem;
        next_quo  = quo;
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        shifted   = {rem[VW-1:0], quo[DW-1]};
        if (start && !busy)
        begin
            next_rem  = '0;
            next_quo  = dividend;
            next_cnt  = CW'(DW);
            next_busy = 1'b1;
        end
        else if (busy)
        begin
            // Remainder stays below divisor, so VW+1 bits never overflow
            if (shifted >= {1'b0, divisor})
            begin
                next_rem = shifted - {1'b0, divisor};
                next_quo = {quo[DW-2:0], 1'b1};
            end
            else
            begin
                next_rem = shifted;
                next_quo = {quo[DW-2:0], 1'b0};
            end
            next_cnt = cnt - CW'(1);
            if (cnt == CW'(1))
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rem  <= '0;
            quo  <= '0;
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            rem  <= next_rem;
            quo  <= next_quo;
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign quotient = quo;
endmodule

// ===== verilog/cpc_current_power.sv
`timescale 1ns/10ps
module cpc_current_power (
    input  wire logic        core_clk,     // System clock, 10 MHz
    input  wire logic        rst,          // Synchronous reset, active high
    input  wire logic        ptrWr,        // Pulse: pointer byte arrives
    input  wire logic [7:0]  ptrByte,      // Register pointer
    input  wire logic        wrByteStb,    // Pulse: data byte written
    input  wire logic [7:0]  wrByte,       // Written data byte
    input  wire logic        rdByteStb,    // Pulse: host wants next byte
    output logic      [7:0]  rdByte,       // Read byte, registered
    output logic             rdByteValid,  // Pulse: rdByte is new
    input  wire logic        sampleStb,    // Pulse: new raw conversion pair
    input  wire logic [15:0] shuntSample,  // Raw shunt result, two's complement
    input  wire logic [12:0] busSample,    // Raw bus result, right-aligned
    output logic      [15:0] setupBits,    // Setup control toward front end
    output logic             calcBusy      // Result computation running
);
    logic [15:0] setupReg;
    logic [15:0] scaleReg;
    logic [15:0] shuntReg;
    logic [15:0] busReg;
    logic [15:0] currReg;
    logic [15:0] powerReg;
    logic [7:0]  ptr;
    logic        wrIdx;
    logic [7:0]  wrHigh;
    logic        rdIdx;
    logic [15:0] rdHold;
    logic        pending;
    cpc_pkg::cpc_state_t state;

    logic [15:0] next_setupReg;
    logic [15:0] next_scaleReg;
    logic [15:0] next_shuntReg;
    logic [15:0] next_busReg;
    logic [15:0] next_currReg;
    logic [15:0] next_powerReg;
    logic [7:0]  next_ptr;
    logic        next_wrIdx;
    logic [7:0]  next_wrHigh;
    logic        next_rdIdx;
    logic [15:0] next_rdHold;
    logic [7:0]  next_rdByte;
    logic        next_rdByteValid;
    logic        next_pending;
    cpc_pkg::cpc_state_t next_state;

    logic        divStart;
    logic [31:0] divDividend;
    logic [15:0] divDivisor;
    logic        divBusy;
    logic        divDone;
    logic [31:0] divQuot;
    logic [15:0] shuntMag;
    logic [15:0] currMag;
    logic [15:0] currClamp;
    logic [15:0] busRight;
    logic        shuntNeg;
    logic        scaleZero;

    // Only setup and scale factor accept host writes
    function automatic logic ptrWritable(input logic [7:0] p);
        ptrWritable = (p == cpc_pkg::PTR_SETUP) || (p == cpc_pkg::PTR_SCALE);
    endfunction

    // Register read decode; unmapped pointers read zero
    function automatic logic [15:0] regRead(
        input logic [7:0]  p,
        input logic [15:0] setupV,
        input logic [15:0] shuntV,
        input logic [15:0] busV,
        input logic [15:0] powerV,
        input logic [15:0] currV,
        input logic [15:0] scaleV
    );
        case (p)
            cpc_pkg::PTR_SETUP: regRead = setupV;
            cpc_pkg::PTR_SHUNT: regRead = shuntV;
            cpc_pkg::PTR_BUS:   regRead = busV;
            cpc_pkg::PTR_POWER: regRead = powerV;
            cpc_pkg::PTR_CURR:  regRead = currV;
            cpc_pkg::PTR_SCALE: regRead = scaleV;
            default:            regRead = cpc_pkg::ZERO16;
        endcase
    endfunction

    // Operand preparation for the shared divider
    always_comb
    begin
        shuntNeg  = shuntReg[15];
        shuntMag  = shuntNeg ? (~shuntReg + 16'h0001) : shuntReg;
        currMag   = currReg[15] ? (~currReg + 16'h0001) : currReg;
        busRight  = busReg >> cpc_pkg::BUS_SHIFT;
        scaleZero = (scaleReg == cpc_pkg::ZERO16);
        currClamp = (divQuot > {16'h0000, cpc_pkg::CURR_MAG_MAX})
                    ? cpc_pkg::CURR_MAG_MAX : divQuot[15:0];
    end

    // Divider inputs follow the sequencer phase
    always_comb
    begin
        divStart    = (state == cpc_pkg::ST_CURR_GO) || (state == cpc_pkg::ST_PWR_GO);
        divDividend = 32'h00000000;
        divDivisor  = cpc_pkg::CURR_DIVISOR;
        if (state == cpc_pkg::ST_CURR_GO || state == cpc_pkg::ST_CURR_WAIT)
        begin
            divDividend = 32'(shuntMag) * 32'(scaleReg);
            divDivisor  = cpc_pkg::CURR_DIVISOR;
        end
        else if (state == cpc_pkg::ST_PWR_GO || state == cpc_pkg::ST_PWR_WAIT)
        begin
            // Power scale is 20 current LSBs because 4 mV times 5000 is 20 V
            divDividend = 32'(currMag) * 32'(busRight);
            divDivisor  = cpc_pkg::PWR_DIVISOR;
        end
    end

    cpc_divider #(
        .DW (32),
        .VW (16)
    ) u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (divStart),
        .dividend (divDividend),
        .divisor  (divDivisor),
        .busy     (divBusy),
        .done     (divDone),
        .quotient (divQuot)
    );

    // Host byte port, register file and result sequencer
    always_comb
    begin
        next_setupReg    = setupReg;
        next_scaleReg    = scaleReg;
        next_shuntReg    = shuntReg;
        next_busReg      = busReg;
        next_currReg     = currReg;
        next_powerReg    = powerReg;
        next_ptr         = ptr;
        next_wrIdx       = wrIdx;
        next_wrHigh      = wrHigh;
        next_rdIdx       = rdIdx;
        next_rdHold      = rdHold;
        next_rdByte      = rdByte;
        next_rdByteValid = 1'b0;
        next_pending     = pending;
        next_state       = state;

        // New conversion pair: store raw values, bus result left-aligned
        if (sampleStb)
        begin
            next_shuntReg = shuntSample;
            next_busReg   = {busSample, {cpc_pkg::BUS_SHIFT{1'b0}}};
            next_pending  = 1'b1;
        end

        // Result sequencer; a trigger during a run is kept for the next run
        case (state)
            cpc_pkg::ST_IDLE:
            begin
                if (pending)
                begin
                    next_pending = sampleStb;
                    next_state   = cpc_pkg::ST_CURR_GO;
                end
            end
            cpc_pkg::ST_CURR_GO:
                next_state = cpc_pkg::ST_CURR_WAIT;
            cpc_pkg::ST_CURR_WAIT:
            begin
                if (divDone)
                begin
                    if (scaleZero)
                    begin
                        next_currReg = cpc_pkg::ZERO16;
                    end
                    else if (shuntNeg)
                    begin
                        next_currReg = ~currClamp + 16'h0001;
                    end
                    else
                    begin
                        next_currReg = currClamp;
                    end
                    next_state = cpc_pkg::ST_PWR_GO;
                end
            end
            cpc_pkg::ST_PWR_GO:
                next_state = cpc_pkg::ST_PWR_WAIT;
            cpc_pkg::ST_PWR_WAIT:
            begin
                if (divDone)
                begin
                    if (scaleZero)
                    begin
                        next_powerReg = cpc_pkg::ZERO16;
                    end
                    else if (divQuot > {16'h0000, cpc_pkg::PWR_MAX})
                    begin
                        next_powerReg = cpc_pkg::PWR_MAX;
                    end
                    else
                    begin
                        next_powerReg = divQuot[15:0];
                    end
                    next_state = cpc_pkg::ST_IDLE;
                end
            end
            default:
                next_state = cpc_pkg::ST_IDLE;
        endcase

        // Pointer byte restarts both byte sequences
        if (ptrWr)
        begin
            next_ptr   = ptrByte;
            next_wrIdx = 1'b0;
            next_rdIdx = 1'b0;
        end
        else if (wrByteStb)
        begin
            if (!wrIdx)
            begin
                next_wrHigh = wrByte;
                next_wrIdx  = 1'b1;
            end
            else
            begin
                next_wrIdx = 1'b0;
                // Applied at the next edge, well inside the settle bound
                if (ptr == cpc_pkg::PTR_SCALE)
                begin
                    next_scaleReg = {wrHigh, wrByte};
                    next_pending  = 1'b1;
                    if ({wrHigh, wrByte} == cpc_pkg::ZERO16)
                    begin
                        next_currReg  = cpc_pkg::ZERO16;
                        next_powerReg = cpc_pkg::ZERO16;
                    end
                end
                else if (ptrWritable(ptr))
                begin
                    // Reset bit acts like power-on and never stays set
                    if (wrHigh[cpc_pkg::SETUP_RST_BIT - 8])
                    begin
                        next_setupReg = cpc_pkg::SETUP_RESET;
                        next_scaleReg = cpc_pkg::SCALE_RESET;
                        next_shuntReg = cpc_pkg::ZERO16;
                        next_busReg   = cpc_pkg::ZERO16;
                        next_currReg  = cpc_pkg::ZERO16;
                        next_powerReg = cpc_pkg::ZERO16;
                        next_pending  = 1'b0;
                        next_state    = cpc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        next_setupReg = {wrHigh, wrByte};
                    end
                end
            end
        end
        else if (rdByteStb)
        begin
            // High byte snapshots the word so the pair stays coherent
            next_rdByteValid = 1'b1;
            if (!rdIdx)
            begin
                next_rdHold = regRead(ptr, setupReg, shuntReg, busReg,
                                      powerReg, currReg, scaleReg);
                next_rdByte = next_rdHold[15:8];
                next_rdIdx  = 1'b1;
            end
            else
            begin
                next_rdByte = rdHold[7:0];
                next_rdIdx  = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            setupReg    <= cpc_pkg::SETUP_RESET;
            scaleReg    <= cpc_pkg::SCALE_RESET;
            shuntReg    <= cpc_pkg::ZERO16;
            busReg      <= cpc_pkg::ZERO16;
            currReg     <= cpc_pkg::ZERO16;
            powerReg    <= cpc_pkg::ZERO16;
            ptr         <= cpc_pkg::PTR_SETUP;
            wrIdx       <= 1'b0;
            wrHigh      <= 8'h00;
            rdIdx       <= 1'b0;
            rdHold      <= cpc_pkg::ZERO16;
            rdByte      <= 8'h00;
            rdByteValid <= 1'b0;
            pending     <= 1'b0;
            state       <= cpc_pkg::ST_IDLE;
        end
        else
        begin
            setupReg    <= next_setupReg;
            scaleReg    <= next_scaleReg;
            shuntReg    <= next_shuntReg;
            busReg      <= next_busReg;
            currReg     <= next_currReg;
            powerReg    <= next_powerReg;
            ptr         <= next_ptr;
            wrIdx       <= next_wrIdx;
            wrHigh      <= next_wrHigh;
            rdIdx       <= next_rdIdx;
            rdHold      <= next_rdHold;
            rdByte      <= next_rdByte;
            rdByteValid <= next_rdByteValid;
            pending     <= next_pending;
            state       <= next_state;
        end
    end

    assign setupBits = setupReg;
    assign calcBusy  = (state != cpc_pkg::ST_IDLE) || divBusy;
endmodule

// ===== bench/cpc_current_power_assertions.sv
`timescale 1ns/10ps
// Port-level checker for the result datapath; sees only the top ports
module cpc_current_power_assertions (
    input  wire logic        core_clk,     // System clock
    input  wire logic        rst,          // Synchronous reset
    input  wire logic        ptrWr,        // Pointer strobe
    input  wire logic [7:0]  ptrByte,      // Pointer value
    input  wire logic        wrByteStb,    // Write byte strobe
    input  wire logic [7:0]  wrByte,       // Write byte
    input  wire logic        rdByteStb,    // Read byte request
    input  wire logic [7:0]  rdByte,       // Read byte
    input  wire logic        rdByteValid,  // Read byte pulse
    input  wire logic        sampleStb,    // New raw pair
    input  wire logic [15:0] shuntSample,  // Raw shunt
    input  wire logic [12:0] busSample,    // Raw bus
    input  wire logic [15:0] setupBits,    // Setup register
    input  wire logic        calcBusy      // Computation running
);
    logic [7:0] ptrSeen;
    logic [7:0] next_ptrSeen;
    logic [7:0] hiByte;
    logic [7:0] next_hiByte;
    logic       hiSeen;
    logic       next_hiSeen;
    logic       trig;
    logic       trigQ;
    logic       trigPend;
    logic       next_trigPend;
    logic       busyQ;

    // Track pointer and byte phase so a completed setup write can be predicted
    always_comb
    begin
        next_ptrSeen = ptrWr ? ptrByte : ptrSeen;
        next_hiSeen  = ptrWr ? 1'b0 : (wrByteStb ? !hiSeen : hiSeen);
        next_hiByte  = (!ptrWr && wrByteStb && !hiSeen) ? wrByte : hiByte;
        // A sample or a finished scale write asks for a run; a run start consumes
        // it, but a trigger in the cycle just before the start is kept for a rerun
        trig          = sampleStb
                        || (!ptrWr && wrByteStb && hiSeen && ptrSeen == cpc_pkg::PTR_SCALE);
        next_trigPend = trig || ((calcBusy && !busyQ) ? trigQ : trigPend);
    end

    always_ff @(posedge core_clk)
    begin
        ptrSeen <= rst ? 8'h00 : next_ptrSeen;
        hiSeen  <= rst ? 1'b0 : next_hiSeen;
        hiByte  <= rst ? 8'h00 : next_hiByte;
        trigPend <= rst ? 1'b0 : next_trigPend;
        trigQ    <= rst ? 1'b0 : trig;
        busyQ    <= rst ? 1'b0 : calcBusy;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_rdValid;
        rdByteStb && !ptrWr && !wrByteStb |=> rdByteValid;
    endproperty
    a_rdValid: assert property (p_rdValid) else $error("read byte not answered");

    property p_rdCause;
        rdByteValid |-> $past(rdByteStb) && !$past(ptrWr) && !$past(wrByteStb);
    endproperty
    a_rdCause: assert property (p_rdCause) else $error("read pulse without request");

    property p_rdStands;
        !rdByteValid |-> $stable(rdByte);
    endproperty
    a_rdStands: assert property (p_rdStands) else $error("read byte moved unasked");

    property p_setupReset;
        $fell(rst) |-> setupBits == cpc_pkg::SETUP_RESET;
    endproperty
    a_setupReset: assert property (p_setupReset) else $error("setup reset value wrong");

    property p_setupHeld;
        $changed(setupBits) |-> $past(wrByteStb);
    endproperty
    a_setupHeld: assert property (p_setupHeld) else $error("setup changed without write");

    // Bit 15 writes are left out: they reset the whole register set
    property p_setupApplied;
        !ptrWr && wrByteStb && hiSeen && ptrSeen == cpc_pkg::PTR_SETUP && !hiByte[7]
            |=> setupBits == {$past(hiByte), $past(wrByte)};
    endproperty
    a_setupApplied: assert property (p_setupApplied) else $error("setup write lost");

    property p_calcCause;
        $rose(calcBusy) |-> trigPend;
    endproperty
    a_calcCause: assert property (p_calcCause) else $error("computation without trigger");

    property p_calcBounded;
        $rose(calcBusy) |-> ##[1:160] !calcBusy;
    endproperty
    a_calcBounded: assert property (p_calcBounded) else $error("computation too long");
endmodule

bind cpc_current_power cpc_current_power_assertions cpc_current_power_assertions_i (
    .core_clk(core_clk), .rst(rst), .ptrWr(ptrWr), .ptrByte(ptrByte),
    .wrByteStb(wrByteStb), .wrByte(wrByte), .rdByteStb(rdByteStb), .rdByte(rdByte),
    .rdByteValid(rdByteValid), .sampleStb(sampleStb), .shuntSample(shuntSample),
    .busSample(busSample), .setupBits(setupBits), .calcBusy(calcBusy)
);

// ===== bench/cpc_host_model.sv
`timescale 1ns/10ps
// Host controller on the byte register port; drives just after each edge
module cpc_host_model (
    input  wire logic       core_clk,     // System clock
    output logic            ptrWr,        // Pointer strobe
    output logic      [7:0] ptrByte,      // Pointer value
    output logic            wrByteStb,    // Write byte strobe
    output logic      [7:0] wrByte,       // Write byte
    output logic            rdByteStb,    // Read byte request
    input  wire logic [7:0] rdByte,       // Returned byte
    input  wire logic       rdByteValid   // Returned byte is new
);
    // Idle port from time zero
    initial
    begin
        ptrWr     = 1'b0;
        ptrByte   = 8'h00;
        wrByteStb = 1'b0;
        wrByte    = 8'h00;
        rdByteStb = 1'b0;
    end

    // Every transfer opens with the pointer byte
    task automatic sendPtr(input logic [7:0] ptr);
        @(posedge core_clk);
        ptrWr   <= 1'b1;
        ptrByte <= ptr;
        @(posedge core_clk);
        ptrWr   <= 1'b0;
    endtask

    // High byte first; then wait out the apply time before any readback
    task automatic writeReg(input logic [7:0] ptr, input logic [15:0] val);
        sendPtr(ptr);
        wrByteStb <= 1'b1;
        wrByte    <= val[15:8];
        @(posedge core_clk);
        wrByte    <= val[7:0];
        @(posedge core_clk);
        wrByteStb <= 1'b0;
        wrByte    <= ~val[7:0]; // Released data must not look valid
        repeat (cpc_pkg::APPLY_CYCLES) @(posedge core_clk);
    endtask

    // Two byte reads; a missing valid pulse poisons the word
    task automatic readReg(input logic [7:0] ptr, output logic [15:0] val);
        sendPtr(ptr);
        rdByteStb <= 1'b1;
        @(posedge core_clk);
        rdByteStb <= 1'b0;
        #1;
        val[15:8] = (rdByteValid === 1'b1) ? rdByte : 8'hxx;
        @(posedge core_clk);
        rdByteStb <= 1'b1;
        @(posedge core_clk);
        rdByteStb <= 1'b0;
        #1;
        val[7:0] = (rdByteValid === 1'b1) ? rdByte : 8'hxx;
    endtask
endmodule

// ===== bench/tb_cpc_current_power.sv
`timescale 1ns/10ps
`define CHECK(got, want) \
    begin \
        totalChecks++; \
        if ((got) !== (want)) \
        begin \
            mismatches++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (want)); \
        end \
    end
module tb_cpc_current_power;
    logic        coreClk     = 1'b0;
    logic        rst         = 1'b1;
    logic        sampleStb   = 1'b0;
    logic [15:0] shuntSample = 16'h0000;
    logic [12:0] busSample   = 13'h0000;
    logic        ptrWr;
    logic [7:0]  ptrByte;
    logic        wrByteStb;
    logic [7:0]  wrByte;
    logic        rdByteStb;
    logic [7:0]  rdByte;
    logic        rdByteValid;
    logic [15:0] setupBits;
    logic        calcBusy;
    int          mismatches  = 0;
    int          totalChecks = 0;

    // 10 MHz clock
    always #50 coreClk = ~coreClk;

    cpc_current_power cpc_current_power_i (
        .core_clk(coreClk), .rst(rst), .ptrWr(ptrWr), .ptrByte(ptrByte),
        .wrByteStb(wrByteStb), .wrByte(wrByte), .rdByteStb(rdByteStb), .rdByte(rdByte),
        .rdByteValid(rdByteValid), .sampleStb(sampleStb), .shuntSample(shuntSample),
        .busSample(busSample), .setupBits(setupBits), .calcBusy(calcBusy)
    );

    cpc_host_model cpc_host_model_i (
        .core_clk(coreClk), .ptrWr(ptrWr), .ptrByte(ptrByte), .wrByteStb(wrByteStb),
        .wrByte(wrByte), .rdByteStb(rdByteStb), .rdByte(rdByte), .rdByteValid(rdByteValid)
    );

    // Reference results: magnitude math, truncation, then clamping
    function automatic logic [31:0] calcExp(input logic [15:0] sh, input logic [12:0] bu,
                                            input logic [15:0] sc);
        longint mag;
        longint cur;
        longint pwr;
        mag = sh[15] ? 65536 - sh : sh;
        cur = (mag * sc) / 4095;
        cur = (cur > 32767) ? 32767 : cur;
        pwr = (cur * bu) / 5000;
        pwr = (pwr > 65535) ? 65535 : pwr;
        cur = sh[15] ? 65536 - cur : cur;
        return {pwr[15:0], cur[15:0]};
    endfunction

    task automatic expectReg(input logic [7:0] ptr, input logic [15:0] want);
        logic [15:0] got;
        cpc_host_model_i.readReg(ptr, got);
        `CHECK(got, want)
    endtask

    // Bounded wait; a pending rerun leaves one idle cycle between runs, so wait for two
    task automatic waitIdle();
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        repeat (3) @(posedge coreClk);
        while (quiet < 2 && n < 400)
        begin
            @(posedge coreClk);
            #1;
            quiet = (calcBusy === 1'b0) ? quiet + 1 : 0;
            n++;
        end
        `CHECK(calcBusy, 1'b0)
    endtask

    task automatic applySample(input logic [15:0] sh, input logic [12:0] bu);
        @(posedge coreClk);
        sampleStb   <= 1'b1;
        shuntSample <= sh;
        busSample   <= bu;
        @(posedge coreClk);
        sampleStb   <= 1'b0;
        waitIdle();
    endtask

    // Reset for 16 cycles, then every pointer reads its reset value
    task automatic testReset();
        @(posedge coreClk);
        rst <= 1'b1;
        repeat (16) @(posedge coreClk);
        rst <= 1'b0;
        for (int p = 0; p < 7; p++)
            expectReg(p[7:0], (p == 0) ? cpc_pkg::SETUP_RESET : cpc_pkg::ZERO16);
        `CHECK(setupBits, cpc_pkg::SETUP_RESET)
        $display("testReset done");
    endtask

    // Worked example: 20 mV shunt, 11.98 V bus, 1 mA current step
    task automatic testExample();
        cpc_host_model_i.writeReg(cpc_pkg::PTR_SETUP, 16'h019f);
        `CHECK(setupBits, 16'h019f)
        cpc_host_model_i.writeReg(cpc_pkg::PTR_SCALE, 16'h5000);
        applySample(16'h07d0, 13'h0bb3);
        expectReg(cpc_pkg::PTR_SHUNT, 16'h07d0);
        expectReg(cpc_pkg::PTR_BUS, 16'h5d98);
        expectReg(cpc_pkg::PTR_CURR, 16'h2712);
        expectReg(cpc_pkg::PTR_POWER, 16'h1767);
        expectReg(cpc_pkg::PTR_SCALE, 16'h5000);
        $display("testExample done");
    endtask

    // Negative, clamped and truncated-to-zero cases
    task automatic testTable();
        logic [15:0] shv [4] = '{16'hf830, 16'h7fff, 16'h8000, 16'h0001};
        logic [12:0] buv [4] = '{13'h0bb3, 13'h1fff, 13'h1fff, 13'h0001};
        logic [15:0] scv [4] = '{16'h5000, 16'hffff, 16'hffff, 16'h0fff};
        logic [31:0] e;
        for (int i = 0; i < 4; i++)
        begin
            cpc_host_model_i.writeReg(cpc_pkg::PTR_SCALE, scv[i]);
            applySample(shv[i], buv[i]);
            e = calcExp(shv[i], buv[i], scv[i]);
            expectReg(cpc_pkg::PTR_CURR, e[15:0]);
            expectReg(cpc_pkg::PTR_POWER, e[31:16]);
            expectReg(cpc_pkg::PTR_BUS, {buv[i], 3'b000});
        end
        $display("testTable done");
    endtask

    // Result registers ignore writes; an unmapped pointer reads zero
    task automatic testReadOnly();
        cpc_host_model_i.writeReg(cpc_pkg::PTR_CURR, 16'h1234);
        cpc_host_model_i.writeReg(cpc_pkg::PTR_SHUNT, 16'h5555);
        cpc_host_model_i.writeReg(8'h06, 16'hbeef);
        expectReg(cpc_pkg::PTR_CURR, 16'h0001);
        expectReg(cpc_pkg::PTR_SHUNT, 16'h0001);
        expectReg(8'h06, 16'h0000);
        $display("testReadOnly done");
    endtask

    // Clearing the scale factor forces both results to zero
    task automatic testScaleZero();
        applySample(16'h07d0, 13'h0bb3);
        cpc_host_model_i.writeReg(cpc_pkg::PTR_SCALE, 16'h0000);
        waitIdle();
        expectReg(cpc_pkg::PTR_CURR, 16'h0000);
        expectReg(cpc_pkg::PTR_POWER, 16'h0000);
        // Setup reset bit acts like power-on and clears itself
        cpc_host_model_i.writeReg(cpc_pkg::PTR_SETUP, 16'h8000);
        `CHECK(setupBits, cpc_pkg::SETUP_RESET)
        expectReg(cpc_pkg::PTR_SHUNT, cpc_pkg::ZERO16);
        $display("testScaleZero done");
    endtask

    task automatic giveVerdict();
        $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence ends with a second reset, issued while the sequencer is idle
    initial
    begin
        testReset();
        testExample();
        testTable();
        testReadOnly();
        testScaleZero();
        testReset();
        giveVerdict();
    end

    // Watchdog: the tests need well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge coreClk);
        mismatches++;
        giveVerdict();
    end
endmodule
